// [core/spsel_top.sv]
// Purpose: Shared pin function select and first power-up sequencing
// Assumes: mclk_i 10 MHz; pins and supply sense are asynchronous
// Notes: Per-line vectors are 32 bits wide; absent lines stay zero
//        Registers survive sleep and wake; only the reset pin clears them
//
// What this block does
// - Codec clock on line 12, select resets 0
// - IR receiver power on line 17, resets 1
// - IR transmit on line 16, select resets 1
// - Card strobes, selects on lines 11..5, reset 1
// - Slot wait inputs on lines 4, 3, reset 1
// - Card direction on line 2, resets 1
// - Power-on reset drives pins to defined state
// - On button moves power-on reset to running
// - Programmed pin states survive sleep and wake
// - Never drive standard inputs on lines 4, 3; shared-line enable still drives them
// - Power-down is inverse of supply-on AND sense
// - Sleep keeps this control logic alive
// - Sleep state only where pin sleep bit set
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module spsel_top (
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port
    input wire spsel_pkg::spsel_req_s req_i,
    output logic [31:0] rdata_o,
    // Pads of the shared lines
    input wire logic [31:0] pad_in_i,
    output spsel_pkg::spsel_drive_s pad_o,
    // Standard functions
    input wire spsel_pkg::spsel_drive_s std_i,
    output logic [31:0] std_in_o,
    // Power control
    input wire logic on_button_i,
    input wire logic system_supply_sense_i,
    output logic supply_on_o,
    output logic powerdown_o
);

    // Input synchronisers, two flops each
    logic [31:0] pad_meta_q;
    logic [31:0] pad_meta_d;
    logic [31:0] pad_sync_q;
    logic [31:0] pad_sync_d;
    logic btn_meta_q;
    logic btn_meta_d;
    logic btn_sync_q;
    logic btn_sync_d;
    logic sense_meta_q;
    logic sense_meta_d;
    logic sense_sync_q;
    logic sense_sync_d;

    // Absent lines masked by a constant so their flops never toggle
    always_comb begin
        pad_meta_d = pad_in_i & spsel_pkg::LINE_MASK;
        pad_sync_d = pad_meta_q;
        btn_meta_d = on_button_i;
        btn_sync_d = btn_meta_q;
        sense_meta_d = system_supply_sense_i;
        sense_sync_d = sense_meta_q;
    end

    // Only the second stage is read by any logic
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_meta_q <= 32'h0;
            pad_sync_q <= 32'h0;
            btn_meta_q <= 1'b0;
            btn_sync_q <= 1'b0;
            sense_meta_q <= 1'b0;
            sense_sync_q <= 1'b0;
        end else begin
            pad_meta_q <= pad_meta_d;
            pad_sync_q <= pad_sync_d;
            btn_meta_q <= btn_meta_d;
            btn_sync_q <= btn_sync_d;
            sense_meta_q <= sense_meta_d;
            sense_sync_q <= sense_sync_d;
        end
    end

    // Software state; only the async reset clears it, never a wake
    logic [31:0] sel_q;
    logic [31:0] sel_d;
    logic [31:0] sleep_sel_q;
    logic [31:0] sleep_sel_d;
    logic [31:0] sio_out_q;
    logic [31:0] sio_out_d;
    logic [31:0] sio_oe_q;
    logic [31:0] sio_oe_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    spsel_pkg::spsel_pstate_e state_q;
    spsel_pkg::spsel_pstate_e state_d;
    logic supply_on_q;
    logic supply_on_d;
    logic powerdown_q;
    logic powerdown_d;
    logic pd_now;
    logic sleep_req;
    logic in_pon;

    // Power-down condition from live supply-on and sensed supply
    assign pd_now = ~(supply_on_q & sense_sync_q);
    assign sleep_req = req_i.wr && (req_i.addr == spsel_pkg::POWER_OFF)
        && req_i.wdata[spsel_pkg::PWR_SLEEP_REQ_BIT];

    // Every line is released until the first press
    assign in_pon = (state_q == spsel_pkg::PS_PON);

    // Software registers; a select write only reroutes its lines
    always_comb begin
        sel_d = sel_q;
        sleep_sel_d = sleep_sel_q;
        sio_out_d = sio_out_q;
        sio_oe_d = sio_oe_q;
        // Writes; unimplemented line bits stay zero
        if (req_i.wr) begin
            case (req_i.addr)
                spsel_pkg::PIN_SEL_OFF: begin
                    sel_d = req_i.wdata & spsel_pkg::LINE_MASK;
                end
                spsel_pkg::SLEEP_SEL_OFF: begin
                    sleep_sel_d = req_i.wdata & spsel_pkg::LINE_MASK;
                end
                spsel_pkg::SIO_OUT_OFF: begin
                    sio_out_d = req_i.wdata & spsel_pkg::LINE_MASK;
                end
                spsel_pkg::SIO_OE_OFF: begin
                    sio_oe_d = req_i.wdata & spsel_pkg::LINE_MASK;
                end
                default: begin
                    // Read-only and unmapped offsets ignore writes
                end
            endcase
        end
    end

    // Only a reset clears these; sleep and wake keep them
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_q <= spsel_pkg::SEL_RST;
            sleep_sel_q <= spsel_pkg::SLEEP_SEL_RST;
            sio_out_q <= spsel_pkg::SIO_OUT_RST;
            sio_oe_q <= spsel_pkg::SIO_OE_RST;
        end else begin
            sel_q <= sel_d;
            sleep_sel_q <= sleep_sel_d;
            sio_out_q <= sio_out_d;
            sio_oe_q <= sio_oe_d;
        end
    end

    // Read mux; the zero default keeps data to a single cycle
    always_comb begin
        rdata_d = 32'h0;
        // Reads answer in the following cycle; unmapped reads zero
        if (req_i.rd) begin
            case (req_i.addr)
                spsel_pkg::PIN_SEL_OFF: begin
                    rdata_d = sel_q;
                end
                spsel_pkg::SLEEP_SEL_OFF: begin
                    rdata_d = sleep_sel_q;
                end
                spsel_pkg::SIO_OUT_OFF: begin
                    rdata_d = sio_out_q;
                end
                spsel_pkg::SIO_OE_OFF: begin
                    rdata_d = sio_oe_q;
                end
                spsel_pkg::SIO_IN_OFF: begin
                    rdata_d = pad_sync_q;
                end
                spsel_pkg::POWER_OFF: begin
                    // Status view of the power sequencer
                    rdata_d[spsel_pkg::PWR_SUPPLY_ON_BIT] = supply_on_q;
                    rdata_d[spsel_pkg::PWR_DOWN_BIT] = powerdown_q;
                    rdata_d[spsel_pkg::PWR_SENSE_BIT] = sense_sync_q;
                    rdata_d[spsel_pkg::PWR_STATE_LSB +: 3] = state_q;
                end
                default: begin
                    rdata_d = 32'h0;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Power sequencing; sleep comes only from a software request
    always_comb begin
        state_d = state_q;
        supply_on_d = supply_on_q;
        powerdown_d = pd_now;
        // Power state machine
        case (state_q)
            spsel_pkg::PS_PON: begin
                // Waits here until the first press
                if (btn_sync_q) begin
                    state_d = spsel_pkg::PS_RUN;
                    supply_on_d = 1'b1;
                end
            end
            spsel_pkg::PS_RUN: begin
                // Button is ignored while running
                if (sleep_req) begin
                    state_d = spsel_pkg::PS_SLEEP;
                    supply_on_d = 1'b0;
                end
            end
            spsel_pkg::PS_SLEEP: begin
                // Logic stays clocked here; supply drops outside
                if (btn_sync_q) begin
                    state_d = spsel_pkg::PS_RUN;
                    supply_on_d = 1'b1;
                end
            end
            default: begin
                // Illegal code falls back to the power-on state
                state_d = spsel_pkg::PS_PON;
                supply_on_d = 1'b0;
            end
        endcase
    end

    // Power state and supply control
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= spsel_pkg::PS_PON;
            supply_on_q <= 1'b0;
            powerdown_q <= 1'b1;
        end else begin
            state_q <= state_d;
            supply_on_q <= supply_on_d;
            powerdown_q <= powerdown_d;
        end
    end

    // Per-line routing between standard function and shared line
    spsel_pkg::spsel_drive_s pad_d;
    logic [31:0] std_in_d;

    for (genvar i = 0; i < 32; i++) begin : g_line
        if (spsel_pkg::LINE_MASK[i]) begin : g_on
            logic gated;
            logic std_oe;
            logic mux_oe;
            logic mux_out;
            // Pins released, not driven low, so outside parts win
            assign gated = in_pon
                || (pd_now && sleep_sel_q[i]);
            // Input-only standard functions never drive the pad
            assign std_oe = std_i.oe[i] & ~spsel_pkg::STD_IN_MASK[i];
            // Shared line or standard function, per select bit
            assign mux_oe = sel_q[i] ? sio_oe_q[i] : std_oe;
            assign mux_out = sel_q[i] ? sio_out_q[i] : std_i.out[i];
            // Gating overrides both sources
            assign pad_d.oe[i] = gated ? 1'b0 : mux_oe;
            assign pad_d.out[i] = gated ? 1'b0 : mux_out;
            assign std_in_d[i] = sel_q[i] ? 1'b0 : pad_sync_q[i];
        end else begin : g_off
            assign pad_d.oe[i] = 1'b0;
            assign pad_d.out[i] = 1'b0;
            assign std_in_d[i] = 1'b0;
        end
    end

    // Output flops; pads start released
    spsel_pkg::spsel_drive_s pad_q;
    logic [31:0] std_in_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_q <= '0;
            std_in_q <= 32'h0;
        end else begin
            pad_q <= pad_d;
            std_in_q <= std_in_d;
        end
    end

    // Ports come straight from flops
    assign pad_o = pad_q;
    assign std_in_o = std_in_q;
    assign rdata_o = rdata_q;
    assign supply_on_o = supply_on_q;
    assign powerdown_o = powerdown_q;

endmodule : spsel_top

`default_nettype wire

// [core/spsel_pkg.sv]
// Purpose: Constants and carrier types for the shared pin select block
// Assumes: 32-bit register port, one word per register
// Notes: Only lines 2..12, 16 and 17 are shared pins in this block
package spsel_pkg;

    // Shared line positions
    localparam int unsigned CODEC_CLK_BIT = 12;
    localparam int unsigned IR_RX_PWR_BIT = 17;
    localparam int unsigned IR_TX_BIT = 16;
    localparam int unsigned CARD_HI_BIT = 11;
    localparam int unsigned CARD_LO_BIT = 5;
    localparam int unsigned SLOT1_WAIT_BIT = 4;
    localparam int unsigned SLOT2_WAIT_BIT = 3;
    localparam int unsigned CARD_DIR_BIT = 2;

    // Lines present in this block
    localparam logic [31:0] LINE_MASK = (32'h1 << IR_RX_PWR_BIT) | (32'h1 << IR_TX_BIT)
        | (32'h1 << CODEC_CLK_BIT) | (((32'h1 << (CARD_HI_BIT + 1)) - 32'h1)
        & ~((32'h1 << CARD_LO_BIT) - 32'h1)) | (32'h1 << SLOT1_WAIT_BIT)
        | (32'h1 << SLOT2_WAIT_BIT) | (32'h1 << CARD_DIR_BIT);
    // Standard function is an input only on these lines
    localparam logic [31:0] STD_IN_MASK = (32'h1 << SLOT1_WAIT_BIT)
        | (32'h1 << SLOT2_WAIT_BIT);

    // Values after reset
    localparam logic [31:0] SEL_RST = LINE_MASK & ~(32'h1 << CODEC_CLK_BIT);
    localparam logic [31:0] SLEEP_SEL_RST = LINE_MASK;
    localparam logic [31:0] SIO_OUT_RST = 32'h0;
    localparam logic [31:0] SIO_OE_RST = 32'h0;

    // Register offsets (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] PIN_SEL_OFF = 8'h00;
    localparam logic [7:0] SLEEP_SEL_OFF = 8'h04;
    localparam logic [7:0] SIO_OUT_OFF = 8'h08;
    localparam logic [7:0] SIO_OE_OFF = 8'h0c;
    localparam logic [7:0] SIO_IN_OFF = 8'h10;
    localparam logic [7:0] POWER_OFF = 8'h14;

    // Power register fields
    localparam int unsigned PWR_SLEEP_REQ_BIT = 0;
    localparam int unsigned PWR_SUPPLY_ON_BIT = 0;
    localparam int unsigned PWR_DOWN_BIT = 1;
    localparam int unsigned PWR_SENSE_BIT = 2;
    localparam int unsigned PWR_STATE_LSB = 4;

    // Power states, one-hot
    typedef enum logic [2:0] {
        PS_PON = 3'h1,
        PS_RUN = 3'h2,
        PS_SLEEP = 3'h4
    } spsel_pstate_e;

    // Pin drive carrier
    typedef struct packed {
        logic [31:0] oe;
        logic [31:0] out;
    } spsel_drive_s;

    // Register bus request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } spsel_req_s;

endpackage : spsel_pkg

// [sim/spsel_chk.sv]
// Purpose: Port-level checks for the shared pin select block
// Assumes: One clock domain, active-low asynchronous reset
// Notes: Bound to the top module from the testbench file
`timescale 1ns/100ps
`default_nettype none

module spsel_chk (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire spsel_pkg::spsel_req_s req_i,
    input wire logic [31:0] rdata_o,
    input wire spsel_pkg::spsel_drive_s pad_o,
    input wire logic [31:0] std_in_o,
    input wire logic on_button_i,
    input wire logic system_supply_sense_i,
    input wire logic supply_on_o,
    input wire logic powerdown_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    logic ran_q;
    logic ran_d;
    logic sleep_wr;
    // First power-up seen; pads must stay released before it
    always_comb ran_d = ran_q | supply_on_o;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) ran_q <= 1'b0;
        else ran_q <= ran_d;
    end
    // Software sleep request on the register port
    always_comb sleep_wr = req_i.wr && (req_i.addr == spsel_pkg::POWER_OFF)
        && req_i.wdata[spsel_pkg::PWR_SLEEP_REQ_BIT];

    // Button held with no competing sleep request
    sequence btn_held;
        (on_button_i && !sleep_wr)[*4];
    endsequence
    // Supply requested and present long enough to pass the synchroniser
    sequence sense_on;
        (supply_on_o && system_supply_sense_i)[*4];
    endsequence

    rd_idle_a: assert property (!$past(req_i.rd) |-> rdata_o == 32'h0)
        else $error("read data not zero outside read slot");
    reset_state_a: assert property ($rose(resetn_i) |->
        pad_o == '0 && powerdown_o && !supply_on_o)
        else $error("bad pin state after reset");
    pon_release_a: assert property (!ran_q && !supply_on_o |-> pad_o == '0)
        else $error("pad driven before first power-up");
    wake_delay_a: assert property (btn_held |-> supply_on_o)
        else $error("button did not start running state");
    supply_drop_a: assert property ($fell(supply_on_o) |->
        $past(sleep_wr) || $past(sleep_wr, 2))
        else $error("supply dropped without sleep request");
    pd_sense_on_a: assert property (sense_on |-> !powerdown_o)
        else $error("powerdown high with supply on and sensed");
    pd_sense_off_a: assert property ((!system_supply_sense_i)[*4] |-> powerdown_o)
        else $error("powerdown low without supply sense");
    pd_supply_a: assert property ((!supply_on_o)[*2] |-> powerdown_o)
        else $error("powerdown low without supply request");
    line_mask_a: assert property (
        ((pad_o.oe | pad_o.out | std_in_o) & ~spsel_pkg::LINE_MASK) == 32'h0)
        else $error("activity on a line that is not shared");
endmodule : spsel_chk

`default_nettype wire

// [sim/spsel_top_test.sv]
// Purpose: Self-checking bench for the shared pin select block
// Assumes: 10 MHz clock, reads answer in the following cycle
// Notes: Directed scenarios; one idle cycle after every bus access
`timescale 1ns/100ps
`default_nettype none

module spsel_top_test;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    spsel_pkg::spsel_req_s req_i = '0;
    spsel_pkg::spsel_drive_s std_i = '0;
    spsel_pkg::spsel_drive_s pad_o;
    logic [31:0] pad_in_i = 32'h0;
    logic [31:0] rdata_o, std_in_o;
    logic on_button_i = 1'b0;
    logic system_supply_sense_i = 1'b0;
    logic supply_on_o, powerdown_o;
    int err_count = 0;
    int comparisons = 0;

    spsel_top i_dut (.mclk_i, .resetn_i, .req_i, .rdata_o, .pad_in_i, .pad_o, .std_i,
        .std_in_o, .on_button_i, .system_supply_sense_i, .supply_on_o, .powerdown_o);

    // Free-running 100 ns clock
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        req_i <= '0;
        @(posedge mclk_i);
    endtask : wr
    // Read data exist only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        req_i <= '0;
        #1 check("rdata", exp, rdata_o);
        @(posedge mclk_i);
    endtask : rd
    // Lets a register write reach the pads and the sync chain settle
    task automatic settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic t_reset;
        #1 check("pad", 32'h0, pad_o.oe | pad_o.out);
        check("powerdown", 32'h1, 32'(powerdown_o));
        @(posedge mclk_i);
        rd(spsel_pkg::PIN_SEL_OFF, 32'h00030ffc);
        rd(spsel_pkg::SLEEP_SEL_OFF, 32'h00031ffc);
        rd(8'h40, 32'h0);
        rd(spsel_pkg::POWER_OFF, 32'h00000012);
        wr(spsel_pkg::POWER_OFF, 32'h1);
        #1 check("supply_on", 32'h0, 32'(supply_on_o));
        @(posedge mclk_i);
    endtask : t_reset
    // Button press, with supply sense present, starts the running state
    task automatic t_up;
        on_button_i <= 1'b1;
        system_supply_sense_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        on_button_i <= 1'b0;
        settle;
        check("supply_on", 32'h1, 32'(supply_on_o));
        check("powerdown", 32'h0, 32'(powerdown_o));
        @(posedge mclk_i);
        rd(spsel_pkg::POWER_OFF, 32'h00000025);
    endtask : t_up
    task automatic t_route;
        std_i <= '{oe: 32'hffffffff, out: 32'haaaaaaaa};
        pad_in_i <= 32'hffffffff;
        wr(spsel_pkg::SIO_OE_OFF, 32'hffffffff);
        wr(spsel_pkg::SIO_OUT_OFF, 32'h55555555);
        settle;
        check("pad_oe", 32'h00031ffc, pad_o.oe);
        check("pad_out", 32'h00010554, pad_o.out);
        check("std_in", 32'h00001000, std_in_o);
        @(posedge mclk_i);
        rd(spsel_pkg::SIO_IN_OFF, 32'h00031ffc);
        wr(spsel_pkg::PIN_SEL_OFF, 32'h0);
        settle;
        check("pad_oe", 32'h00031fe4, pad_o.oe);
        check("pad_out", 32'h00020aa8, pad_o.out);
        check("std_in", 32'h00031ffc, std_in_o);
        @(posedge mclk_i);
    endtask : t_route
    // Only line 16 is released in sleep; registers must survive the wake
    task automatic t_sleep;
        wr(spsel_pkg::SLEEP_SEL_OFF, 32'h00010000);
        wr(spsel_pkg::POWER_OFF, 32'h1);
        settle;
        check("supply_on", 32'h0, 32'(supply_on_o));
        check("pad_oe", 32'h00021fe4, pad_o.oe);
        @(posedge mclk_i);
        rd(spsel_pkg::SIO_OE_OFF, 32'h00031ffc);
        t_up;
        rd(spsel_pkg::PIN_SEL_OFF, 32'h0);
        rd(spsel_pkg::SLEEP_SEL_OFF, 32'h00010000);
    endtask : t_sleep
    task automatic print_verdict;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_reset;
        t_up;
        t_route;
        t_sleep;
        print_verdict;
    end
    // Watchdog well beyond the 81 cycles needed
    initial begin
        repeat (3000) @(posedge mclk_i);
        err_count++;
        print_verdict;
    end
endmodule : spsel_top_test

bind spsel_top spsel_chk i_chk (.mclk_i, .resetn_i, .req_i, .rdata_o, .pad_o, .std_in_o,
    .on_button_i, .system_supply_sense_i, .supply_on_o, .powerdown_o);

`default_nettype wire
